// >>> core_access_model.sv
// Purpose: load/store and fetch path model that presents one access per request
// Assumes: bench pulses go for one cycle with the access in req
// Notes:   outside a valid cycle the address keeps changing so nothing stale reads as valid
`timescale 1ns/1ps

module core_access_model (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // request from the bench
    input  wire logic                 go,
    input  wire mem_map_pkg::access_t req,
    // access toward the decoder
    output mem_map_pkg::access_t      acc
);

    // one valid cycle per request, then released with a toggling address
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc <= '0;
        end else if (go) begin
            // word aligned, so no access ever straddles a segment boundary
            acc <= '{req.valid, {req.physical_address[31:2], 2'h0}, req.fetch,
                     req.write, req.priv, req.bigEndian};
        end else begin
            acc.valid            <= 1'b0;
            acc.physical_address <= ~acc.physical_address;
        end
    end

endmodule

// >>> default_memory_map_decode.sv
// Purpose: default physical address attribute decode, fault routing and
//          private peripheral region access checks, with an AHB-Lite control port
// Assumes: requests are synchronous to mclk; protection region answer is same cycle
// Notes:   attributes and faults are combinational from the presented access
//
// Notes on behaviour
// - segment 000 normal, write-through, executable
// - segment 001 normal, write-back allocate
// - segment 010 device, execute-never
// - segment 011 normal, write-back allocate
// - segment 100 normal, write-through
// - segments 101/110 device, shared/unshared, execute-never
// - private peripheral strongly ordered, rest device
// - outer attribute always equals inner
// - fetch from execute-never faults
// - disabled management fault escalates
// - default map used when protection off
// - background map for privileged when enabled
// - protection cannot relax system segment attributes
// - private peripheral accesses always little-endian
// - clear-on-read bits keep a coincident event only if the bit read as zero
// - reserved fields read fixed, written zero
// - unprivileged peripheral access raises bus fault
// - trigger register unprivileged when enabled
// - cache policy may be demoted, never promoted
`timescale 1ns/1ps

module default_memory_map_decode (
    // clock and reset
    input  wire logic                     mclk,
    input  wire logic                     rst,
    // ahb-lite register port
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic                          hreadyout,
    output logic [31:0]                   hrdata,
    output logic                          hresp,
    // access from the processor path
    input  wire mem_map_pkg::access_t     acc,
    // answer of the protection region logic
    input  wire mem_map_pkg::protRegion_t region,
    // resulting attributes and faults
    output mem_map_pkg::memAttr_t         attr,
    output logic                          memory_management_fault,
    output logic                          escalated_fault,
    output logic                          bus_error_fault,
    output logic                          swapBytes
);

    // default attributes from the top address bits
    function automatic mem_map_pkg::memAttr_t defaultAttr(input logic [31:0] a);
        mem_map_pkg::memAttr_t r;
        r.memType   = mem_map_pkg::MT_DEVICE;
        r.inner     = mem_map_pkg::CACHE_NC;
        r.shareable = 1'b0;
        r.xn        = 1'b1;
        unique case (a[31:29])
            // code: normal write-through
            mem_map_pkg::SEG_CODE: begin
                r.memType = mem_map_pkg::MT_NORMAL;
                r.inner   = mem_map_pkg::CACHE_WT;
                r.xn      = 1'b0;
            end
            // sram: normal write-back allocate
            mem_map_pkg::SEG_SRAM: begin
                r.memType = mem_map_pkg::MT_NORMAL;
                r.inner   = mem_map_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY;
                r.xn      = 1'b0;
            end
            // peripheral: device, never executed
            mem_map_pkg::SEG_PERIPH: begin
                r.memType = mem_map_pkg::MT_DEVICE;
            end
            // external ram with write-back allocate
            mem_map_pkg::SEG_RAM_WB: begin
                r.memType = mem_map_pkg::MT_NORMAL;
                r.inner   = mem_map_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY;
                r.xn      = 1'b0;
            end
            // external ram with write-through
            mem_map_pkg::SEG_RAM_WT: begin
                r.memType = mem_map_pkg::MT_NORMAL;
                r.inner   = mem_map_pkg::CACHE_WT;
                r.xn      = 1'b0;
            end
            // shared device space
            mem_map_pkg::SEG_DEV_SH: begin
                r.shareable = 1'b1;
            end
            // non-shared device space
            mem_map_pkg::SEG_DEV_NS: begin
                r.shareable = 1'b0;
            end
            // system segment: private peripherals or vendor devices
            mem_map_pkg::SEG_SYSTEM: begin
                if (a[28:20] == 9'h000) begin
                    r.memType   = mem_map_pkg::MT_STRONG;
                    r.shareable = 1'b1;
                end
            end
        endcase
        r.outer = r.inner;
        return r;
    endfunction

    // private peripheral region hit
    function automatic logic isPpb(input logic [31:0] a);
        return (a[31:29] == mem_map_pkg::SEG_SYSTEM) && (a[28:20] == 9'h000);
    endfunction

    // caching strength: write_back_allocate_policy above wt above non-cached
    function automatic logic [1:0] cacheRank(input logic [1:0] c);
        logic [1:0] k;
        k = 2'h0;
        if (c == mem_map_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY) begin
            k = 2'h2;
        end else if (c == mem_map_pkg::CACHE_WT) begin
            k = 2'h1;
        end
        return k;
    endfunction

    // state registers and next state
    mem_map_pkg::state_t stateFf;
    mem_map_pkg::state_t nxtState;

    // decode helpers
    mem_map_pkg::memAttr_t dflt;          // default map answer
    mem_map_pkg::memAttr_t eff;           // attributes actually applied
    logic                  inSystem;      // top segment
    logic                  inPpb;         // private peripheral region
    logic                  protOn;        // protection enabled
    logic                  bgAllowed;     // background map usable
    logic                  violation;     // access violation of any kind
    logic                  unprivBad;     // unprivileged peripheral access
    logic                  trigOk;        // unprivileged trigger allowed
    logic                  addrPhase;     // ahb address phase taken
    logic [7:0]            aOff;          // offset in address phase
    logic [31:0]           rdNext;        // read value for next data phase

    // attribute selection, purely combinational
    always_comb begin
        dflt      = defaultAttr(acc.physical_address);
        inSystem  = acc.physical_address[31:29] == mem_map_pkg::SEG_SYSTEM;
        inPpb     = isPpb(acc.physical_address);
        protOn    = stateFf.ctrl[mem_map_pkg::CTRL_PROT_EN];
        bgAllowed = acc.priv && stateFf.ctrl[mem_map_pkg::CTRL_PRIV_BG];
        eff       = dflt;
        if (protOn && region.hit) begin
            // programmed region, limited to demotion of the cache policy
            eff = region.attr;
            if (cacheRank(region.attr.inner) > cacheRank(dflt.inner)) begin
                eff.inner = dflt.inner;
            end
            // system segment keeps execute-never and never becomes normal
            if (inSystem) begin
                eff.xn = 1'b1;
                if (region.attr.memType == mem_map_pkg::MT_NORMAL) begin
                    eff.memType = dflt.memType;
                end
            end
            // private peripherals are not remapped
            if (inPpb) begin
                eff = dflt;
            end
            eff.outer = eff.inner;
        end
        attr = eff;
    end

    // access checks and fault routing
    always_comb begin
        violation = 1'b0;
        if (acc.valid) begin
            if (acc.fetch && eff.xn) begin
                violation = 1'b1;
            end
            if (protOn && region.hit && region.deny && !inPpb) begin
                violation = 1'b1;
            end
            if (protOn && !region.hit && !bgAllowed) begin
                violation = 1'b1;
            end
        end
        trigOk    = (acc.physical_address[31:2] == mem_map_pkg::TRIG_ADDR[31:2])
                    && stateFf.ctrl[mem_map_pkg::CTRL_UNPRIV_T];
        unprivBad = acc.valid && inPpb && !acc.priv && !trigOk;
        memory_management_fault = violation && stateFf.ctrl[mem_map_pkg::CTRL_MM_EN];
        escalated_fault         = violation && !stateFf.ctrl[mem_map_pkg::CTRL_MM_EN];
        bus_error_fault         = unprivBad && !violation;
        swapBytes               = acc.valid && acc.bigEndian && !inPpb;
    end

    // ahb responses: zero wait, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = stateFf.rdData;

    // register file and event capture
    always_comb begin
        nxtState  = stateFf;
        addrPhase = hsel && htrans[1] && hready;
        aOff      = haddr[7:0];
        rdNext    = 32'h0000_0000; // unmapped and reserved bits read zero
        unique case (aOff)
            mem_map_pkg::OFF_CTRL:   rdNext = {28'h000_0000, stateFf.ctrl};
            mem_map_pkg::OFF_STATUS: rdNext = {29'h0000_0000, stateFf.sticky};
            mem_map_pkg::OFF_FADDR:  rdNext = stateFf.faultAddr;
            default:                 rdNext = 32'h0000_0000;
        endcase
        // hold read data through the data phase
        nxtState.dWrite = 1'b0;
        if (addrPhase) begin
            nxtState.dAddr  = aOff;
            nxtState.dWrite = hwrite;
            nxtState.dWord  = hsize == mem_map_pkg::HSIZE_WORD;
            if (!hwrite) begin
                nxtState.rdData = rdNext;
            end
        end
        // sticky events, read clears only what was seen as one
        if (addrPhase && !hwrite && aOff == mem_map_pkg::OFF_STATUS) begin
            nxtState.sticky[mem_map_pkg::ST_MM]  = !stateFf.sticky[mem_map_pkg::ST_MM]
                                                   && memory_management_fault;
            nxtState.sticky[mem_map_pkg::ST_ESC] = !stateFf.sticky[mem_map_pkg::ST_ESC]
                                                   && escalated_fault;
            nxtState.sticky[mem_map_pkg::ST_BUS] = !stateFf.sticky[mem_map_pkg::ST_BUS]
                                                   && bus_error_fault;
        end else begin
            nxtState.sticky[mem_map_pkg::ST_MM]  = stateFf.sticky[mem_map_pkg::ST_MM]
                                                   || memory_management_fault;
            nxtState.sticky[mem_map_pkg::ST_ESC] = stateFf.sticky[mem_map_pkg::ST_ESC]
                                                   || escalated_fault;
            nxtState.sticky[mem_map_pkg::ST_BUS] = stateFf.sticky[mem_map_pkg::ST_BUS]
                                                   || bus_error_fault;
        end
        // latest faulting address
        if (violation || unprivBad) begin
            nxtState.faultAddr = acc.physical_address;
        end
        // word write to control; other sizes ignored
        if (stateFf.dWrite && stateFf.dWord && stateFf.dAddr == mem_map_pkg::OFF_CTRL) begin
            nxtState.ctrl = hwdata[3:0];
        end
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stateFf.ctrl      <= mem_map_pkg::CTRL_RESET;
            stateFf.sticky    <= mem_map_pkg::STATUS_RESET;
            stateFf.faultAddr <= mem_map_pkg::FADDR_RESET;
            stateFf.rdData    <= 32'h0000_0000;
            stateFf.dAddr     <= 8'h00;
            stateFf.dWrite    <= 1'b0;
            stateFf.dWord     <= 1'b0;
        end else begin
            stateFf <= nxtState;
        end
    end

    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_code_wt: assert property (
        !protOn && acc.physical_address[31:29] == mem_map_pkg::SEG_CODE |->
        attr.memType == mem_map_pkg::MT_NORMAL && attr.inner == mem_map_pkg::CACHE_WT
        && !attr.xn && !attr.shareable)
        else $error("code segment attributes wrong");

    chk_sram_write_back_allocate_policy: assert property (
        !protOn && acc.physical_address[31:29] == mem_map_pkg::SEG_SRAM |->
        attr.inner == mem_map_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY && !attr.xn)
        else $error("sram segment attributes wrong");

    chk_periph_xn: assert property (
        !protOn && acc.physical_address[31:29] == mem_map_pkg::SEG_PERIPH |->
        attr.memType == mem_map_pkg::MT_DEVICE && attr.xn && attr.inner == 2'h0)
        else $error("peripheral segment attributes wrong");

    chk_ppb_strong: assert property (
        isPpb(acc.physical_address) |->
        attr.memType == mem_map_pkg::MT_STRONG && attr.shareable && attr.xn)
        else $error("private peripheral attributes wrong");

    chk_outer_inner: assert property (attr.outer == attr.inner)
        else $error("outer differs from inner");

    chk_fetch_xn: assert property (
        acc.valid && acc.fetch && attr.xn |->
        memory_management_fault || escalated_fault)
        else $error("fetch from execute-never not faulted");

    chk_fault_route: assert property (
        memory_management_fault || escalated_fault |->
        memory_management_fault == stateFf.ctrl[mem_map_pkg::CTRL_MM_EN])
        else $error("fault routed against enable");

    chk_sys_xn: assert property (inSystem |-> attr.xn
        && attr.memType != mem_map_pkg::MT_NORMAL)
        else $error("system segment relaxed");

    chk_cor_read: assert property (
        addrPhase && !hwrite && aOff == mem_map_pkg::OFF_STATUS
        && stateFf.sticky[mem_map_pkg::ST_BUS] |=>
        hrdata[mem_map_pkg::ST_BUS] && !stateFf.sticky[mem_map_pkg::ST_BUS])
        else $error("read did not clear a set bit");

    chk_unpriv_bus: assert property (
        acc.valid && isPpb(acc.physical_address) && !acc.priv && !trigOk && !violation
        |-> bus_error_fault ##1 stateFf.sticky[mem_map_pkg::ST_BUS])
        else $error("unprivileged peripheral access not faulted");

    chk_ppb_endian: assert property (
        acc.valid && isPpb(acc.physical_address) |-> !swapBytes)
        else $error("peripheral access swapped");

    cov_bg_map: cover property (acc.valid && protOn && !region.hit && bgAllowed);
    cov_escalate: cover property (escalated_fault ##1 stateFf.sticky[mem_map_pkg::ST_ESC]);
    cov_trig_unpriv: cover property (acc.valid && !acc.priv && trigOk && inPpb);
    cov_cor_coincide: cover property (addrPhase && !hwrite && aOff == mem_map_pkg::OFF_STATUS
        && bus_error_fault && !stateFf.sticky[mem_map_pkg::ST_BUS]);

endmodule

// >>> mem_map_pkg.sv
// Purpose: shared constants and types for the default memory map decoder
// Assumes: 32-bit physical addresses, AHB-Lite register port with word data
// Notes:   cache codes follow the inner/outer attribute encoding of the decode
package mem_map_pkg;

    // memory types produced by the decode
    typedef enum logic [1:0] {
        MT_NORMAL,
        MT_DEVICE,
        MT_STRONG
    } memType_t;

    // cache attribute codes (inner and outer)
    localparam logic [1:0] CACHE_NC   = 2'h0;   // non-cacheable
    localparam logic [1:0] CACHE_WRITE_BACK_ALLOCATE_POLICY = 2'h1;   // write-back, write allocate
    localparam logic [1:0] CACHE_WT   = 2'h2;   // write-through

    // top three address bits of each 0.5GB segment
    localparam logic [2:0] SEG_CODE   = 3'h0;
    localparam logic [2:0] SEG_SRAM   = 3'h1;
    localparam logic [2:0] SEG_PERIPH = 3'h2;
    localparam logic [2:0] SEG_RAM_WB = 3'h3;
    localparam logic [2:0] SEG_RAM_WT = 3'h4;
    localparam logic [2:0] SEG_DEV_SH = 3'h5;
    localparam logic [2:0] SEG_DEV_NS = 3'h6;
    localparam logic [2:0] SEG_SYSTEM = 3'h7;

    // software trigger register word address, reachable unprivileged when enabled
    localparam logic [31:0] TRIG_ADDR = 32'hE000_EF00;

    // register offsets (byte addresses within the slave)
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_FADDR  = 8'h08;

    // control register bit positions
    localparam int CTRL_PROT_EN  = 0;
    localparam int CTRL_PRIV_BG  = 1;
    localparam int CTRL_MM_EN    = 2;
    localparam int CTRL_UNPRIV_T = 3;

    // status register bit positions (clear on read)
    localparam int ST_MM  = 0;
    localparam int ST_ESC = 1;
    localparam int ST_BUS = 2;

    // reset values
    localparam logic [3:0]  CTRL_RESET   = 4'h0;
    localparam logic [2:0]  STATUS_RESET = 3'h0;
    localparam logic [31:0] FADDR_RESET  = 32'h0000_0000;

    // ahb constants
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    // attributes of one access
    typedef struct packed {
        memType_t   memType;
        logic [1:0] inner;
        logic [1:0] outer;
        logic       shareable;
        logic       xn;
    } memAttr_t;

    // access presented by the load/store and fetch path
    typedef struct packed {
        logic        valid;
        logic [31:0] physical_address;
        logic        fetch;
        logic        write;
        logic        priv;
        logic        bigEndian;
    } access_t;

    // answer of the programmable protection region logic
    typedef struct packed {
        logic     hit;
        logic     deny;
        memAttr_t attr;
    } protRegion_t;

    // all state of the decoder
    typedef struct packed {
        logic [3:0]  ctrl;
        logic [2:0]  sticky;
        logic [31:0] faultAddr;
        logic [31:0] rdData;
        logic [7:0]  dAddr;
        logic        dWrite;
        logic        dWord;
    } state_t;

endpackage

// >>> testbench.sv
// Purpose: self-checking bench for the default memory map decoder
// Assumes: zero wait state slave, combinational attribute outputs
// Notes:   random addresses from a fixed seed plus segment corner cases
`timescale 1ns/1ps

module testbench;

    // clock, reset and bus
    logic                       mclk;
    logic                       rst;
    logic                       hsel;
    logic [31:0]                haddr;
    logic [1:0]                 htrans;
    logic                       hwrite;
    logic [2:0]                 hsize;
    logic [31:0]                hwdata;
    logic                       hreadyout;
    logic [31:0]                hrdata;
    logic                       hresp;
    // access path
    logic                       go;
    mem_map_pkg::access_t       req;
    mem_map_pkg::access_t       acc;
    mem_map_pkg::protRegion_t   region;
    mem_map_pkg::memAttr_t      attr;
    logic                       memory_management_fault;
    logic                       escalated_fault;
    logic                       bus_error_fault;
    logic                       swapBytes;
    // bookkeeping
    int                         n_errors;
    int                         check_count;
    integer                     seed;
    logic [31:0]                corner [4];

    default_memory_map_decode DUT (
        .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .acc(acc), .region(region),
        .attr(attr), .memory_management_fault(memory_management_fault),
        .escalated_fault(escalated_fault), .bus_error_fault(bus_error_fault),
        .swapBytes(swapBytes)
    );

    core_access_model core (
        .mclk(mclk), .rst(rst), .go(go), .req(req), .acc(acc)
    );

    // free running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // expected default attributes of an address
    function automatic mem_map_pkg::memAttr_t defAttr(input logic [31:0] a);
        mem_map_pkg::memAttr_t m;
        m = '{mem_map_pkg::MT_DEVICE, mem_map_pkg::CACHE_NC, 2'h0, 1'b0, 1'b1};
        case (a[31:29])
            3'h0, 3'h4: m = '{mem_map_pkg::MT_NORMAL, mem_map_pkg::CACHE_WT, 2'h0, 1'b0, 1'b0};
            3'h1, 3'h3: m = '{mem_map_pkg::MT_NORMAL, mem_map_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY, 2'h0, 1'b0, 1'b0};
            3'h5: m.shareable = 1'b1;
            3'h7: if (a[28:20] === 9'h000) m = '{mem_map_pkg::MT_STRONG, 2'h0, 2'h0, 1'b1, 1'b1};
            default: ;
        endcase
        m.outer = m.inner;
        return m;
    endfunction

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one single word transfer, address phase then data phase
    task automatic ahb(input logic w, input logic [7:0] off, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= 32'(off);
        hwrite <= w;
        hsize  <= mem_map_pkg::HSIZE_WORD;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] off, input logic [31:0] wd);
        logic [31:0] d;
        ahb(1'b1, off, wd, d);
    endtask

    task automatic rdChk(input logic [7:0] off, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, off, 32'h0000_0000, d);
        check(d, exp);
    endtask

    // present one access and compare attributes and {mm, esc, bus, swap}
    task automatic probe(input logic [31:0] a, input logic f, input logic p, input logic b,
                         input mem_map_pkg::protRegion_t rg, input logic chk,
                         input mem_map_pkg::memAttr_t ea, input logic [3:0] ef,
                         output mem_map_pkg::memAttr_t sa);
        req    <= '{1'b1, a, f, 1'b0, p, b};
        region <= rg;
        go     <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        #1;
        sa = attr;
        if (chk) begin
            check(32'(attr), 32'(ea));
        end
        check(32'({memory_management_fault, escalated_fault, bus_error_fault, swapBytes}),
              32'(ef));
        @(posedge mclk);
    endtask

    // status read in the same cycle as a fetch fault
    task automatic coin(input logic [31:0] first, input logic [31:0] second);
        req    <= '{1'b1, 32'h4000_0000, 1'b1, 1'b0, 1'b1, 1'b0};
        region <= '0;
        go     <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        rdChk(mem_map_pkg::OFF_STATUS, first);
        rdChk(mem_map_pkg::OFF_STATUS, second);
    endtask

    // verdict and end of run
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        test_done();
    end

    // main sequence
    initial begin
        logic [31:0]              a;
        logic                     f;
        logic                     b;
        logic [3:0]               ef;
        mem_map_pkg::memAttr_t    ea;
        mem_map_pkg::memAttr_t    sa;
        mem_map_pkg::protRegion_t rg;
        mem_map_pkg::protRegion_t rgN;
        seed   = 32'ha818_58c2;
        corner = '{32'h1FFF_FFFC, 32'h2000_0000, 32'hE00F_FFFC, 32'hE010_0000};
        rgN    = '{1'b1, 1'b0, '{mem_map_pkg::MT_NORMAL, mem_map_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY,
                   mem_map_pkg::CACHE_WRITE_BACK_ALLOCATE_POLICY, 1'b0, 1'b0}};
        n_errors = 0;
        check_count = 0;
        rst = 1'b1;
        {hsel, haddr, htrans, hwrite, hwdata, go} = '0;
        hsize  = mem_map_pkg::HSIZE_WORD;
        req    = '0;
        region = '0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdChk(mem_map_pkg::OFF_CTRL, 32'h0000_0000);
        rdChk(mem_map_pkg::OFF_FADDR, 32'h0000_0000);
        wr(8'h10, 32'hFFFF_FFFF);
        rdChk(8'h10, 32'h0000_0000);
        // default map over every segment, protection off, region input random
        for (int i = 0; i < 28; i++) begin
            a = 32'($random(seed));
            a[31:29] = 3'(i);
            if (i[3]) a[28:20] = 9'h000;
            if (i >= 24) a = corner[i - 24];
            f  = 1'($random(seed));
            b  = 1'($random(seed));
            ea = defAttr(a);
            ef = {1'b0, f & ea.xn, 1'b0, b & (a[31:20] !== 12'he00)};
            rg = mem_map_pkg::protRegion_t'(10'($random(seed)));
            probe(a, f, 1'b1, b, rg, 1'b1, ea, ef, sa);
        end
        probe(32'hC000_0100, 1'b1, 1'b1, 1'b0, '0, 1'b1, defAttr(32'hC000_0100), 4'b0100, sa);
        probe(32'hE000_ED00, 1'b0, 1'b1, 1'b1, '0, 1'b1, defAttr(32'hE000_ED00), 4'b0000, sa);
        probe(32'h6000_0000, 1'b0, 1'b1, 1'b1, '0, 1'b1, defAttr(32'h6000_0000), 4'b0001, sa);
        wr(mem_map_pkg::OFF_CTRL, 32'h0000_0004);
        rdChk(mem_map_pkg::OFF_STATUS, 32'h0000_0002);
        rdChk(mem_map_pkg::OFF_FADDR, 32'hC000_0100);
        probe(32'h4000_0010, 1'b1, 1'b1, 1'b0, '0, 1'b1, defAttr(32'h4000_0010), 4'b1000, sa);
        rdChk(mem_map_pkg::OFF_STATUS, 32'h0000_0001);
        rdChk(mem_map_pkg::OFF_STATUS, 32'h0000_0000);
        // unprivileged private peripheral accesses
        a = mem_map_pkg::TRIG_ADDR;
        probe(32'hE000_E010, 1'b0, 1'b0, 1'b0, '0, 1'b1, defAttr(a), 4'b0010, sa);
        probe(a, 1'b0, 1'b0, 1'b0, '0, 1'b1, defAttr(a), 4'b0010, sa);
        wr(mem_map_pkg::OFF_CTRL, 32'h0000_000C);
        probe(a, 1'b0, 1'b0, 1'b0, '0, 1'b1, defAttr(a), 4'b0000, sa);
        rdChk(mem_map_pkg::OFF_FADDR, a);
        rdChk(mem_map_pkg::OFF_STATUS, 32'h0000_0004);
        // protection enabled: background map, demotion, system segment limits
        a = 32'h2000_0040;
        wr(mem_map_pkg::OFF_CTRL, 32'h0000_0005);
        probe(a, 1'b0, 1'b1, 1'b0, '0, 1'b0, defAttr(a), 4'b1000, sa);
        wr(mem_map_pkg::OFF_CTRL, 32'h0000_0007);
        probe(a, 1'b0, 1'b1, 1'b0, '0, 1'b1, defAttr(a), 4'b0000, sa);
        ea = '{mem_map_pkg::MT_NORMAL, mem_map_pkg::CACHE_WT, mem_map_pkg::CACHE_WT, 1'b0, 1'b0};
        probe(32'h0000_1000, 1'b0, 1'b1, 1'b0, rgN, 1'b1, ea, 4'b0000, sa);
        probe(32'hE004_0000, 1'b0, 1'b1, 1'b0, rgN, 1'b0, ea, 4'b0000, sa);
        check(32'(sa.xn), 32'h0000_0001);
        check(32'(sa.memType === mem_map_pkg::MT_NORMAL), 32'h0000_0000);
        probe(32'hE000_E000, 1'b0, 1'b1, 1'b0, rgN, 1'b1, defAttr(32'hE000_E000), 4'b0, sa);
        rdChk(mem_map_pkg::OFF_STATUS, 32'h0000_0001);
        // clear-on-read against a coincident setting event
        coin(32'h0000_0000, 32'h0000_0001);
        probe(32'h4000_0000, 1'b1, 1'b1, 1'b0, '0, 1'b1, defAttr(32'h4000_0000), 4'b1000, sa);
        coin(32'h0000_0001, 32'h0000_0000);
        rdChk(mem_map_pkg::OFF_CTRL, 32'h0000_0007);
        test_done();
    end

endmodule
